// >>> rtl/tkc_regs.vh
// Register map, field positions and timing constants of the touch-key core
`ifndef TKC_REGS_VH
`define TKC_REGS_VH
`define TKC_NKEYS        24
`define TKC_KW           5
`define TKC_ADR_CTRL     8'h00
`define TKC_ADR_STATUS   8'h04
`define TKC_ADR_KEYEN    8'h08
`define TKC_ADR_ACTIVE   8'h0c
`define TKC_ADR_CALBUSY  8'h10
`define TKC_ADR_CALERR   8'h14
`define TKC_ADR_STERR    8'h18
`define TKC_ADR_LIMSEL   8'h1c
`define TKC_ADR_LIMDAT   8'h20
`define TKC_ADR_CMD      8'h24
`define TKC_CMD_FRESET   8'h04
`define TKC_CMD_LASTCMD  8'h0f
`define TKC_CTRL_MOD     0
`define TKC_ST_INIT      0
`define TKC_ST_READY     1
`define TKC_ST_DETECT    2
`define TKC_ST_ERR       3
`define TKC_ST_CAL       4
`define TKC_ST_CHIRP     5
`define TKC_KEYEN_RST    24'hffffff
`define TKC_CAL_TRIES    3'h5
`define TKC_CLK_MHZ      100
`define TKC_INIT_US      4000
`define TKC_INITMOD_US   22000
`define TKC_RSTPIN_US    10
`define TKC_STEST_US     1000000
`define TKC_RSTPIN_CYC   (`TKC_RSTPIN_US * `TKC_CLK_MHZ)
`endif

// >>> rtl/tkc_core.v
// Touch-key sequencer: reset, init, calibration, confirmation, self-test
//
// The register offsets and the Wishbone register port were decided locally.
`default_nettype none
`include "tkc_regs.vh"

module tkc_core #(
  parameter INIT_CYC    = `TKC_INIT_US * `TKC_CLK_MHZ,
  parameter INITMOD_CYC = `TKC_INITMOD_US * `TKC_CLK_MHZ,
  parameter STEST_CYC   = `TKC_STEST_US * `TKC_CLK_MHZ
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        rst_pin_n,
  input  wire        link_clk,
  input  wire [23:0] cross_in,
  input  wire [23:0] low_sig_in,
  input  wire [8:0]  fault_in,
  input  wire        sample_vld,
  input  wire        cal_ok,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         ready_r,
  output reg         burst_r,
  output reg         chirp_r,
  output reg  [4:0]  key_sel_r,
  output reg         stest_slot_r,
  output reg  [23:0] active_r
);

  // ************************************************************
  // Reset sources
  // ************************************************************
  reg  [2:0]  rpin_s_r;
  reg         rpin_q_r;
  reg  [19:0] rlow_cnt_r;
  reg         pin_rst_r;
  reg         cmd_rst_r;
  wire        irst = srst | pin_rst_r | cmd_rst_r;

  always @(posedge mclk)
  begin
    rpin_s_r <= {rpin_s_r[1:0], rst_pin_n};
    if (srst)
    begin
      rpin_q_r   <= 1'b1;
      rlow_cnt_r <= 20'h00000;
      pin_rst_r  <= 1'b0;
    end
    else
    begin
      if (rpin_s_r[2] == rpin_s_r[1])
        rpin_q_r <= rpin_s_r[2];
      if (rpin_q_r)
        rlow_cnt_r <= 20'h00000;
      else if (rlow_cnt_r != 20'hfffff)
        rlow_cnt_r <= rlow_cnt_r + 20'h00001;
      // Full reset once low long enough, held until release
      pin_rst_r <= !rpin_q_r &&
                   (rlow_cnt_r >= `TKC_RSTPIN_CYC - 1);
    end
  end

  // ************************************************************
  // Link clock level sync (kept, but no logic reads lclk_q_r)
  // ************************************************************
  reg [2:0] lclk_s_r;
  reg       lclk_q_r;
  always @(posedge mclk)
  begin
    lclk_s_r <= {lclk_s_r[1:0], link_clk};
    if (srst)
      lclk_q_r <= 1'b1;
    else if (lclk_s_r[2] == lclk_s_r[1])
      lclk_q_r <= lclk_s_r[2];
  end

  // ************************************************************
  // Registers and bus slave
  // ************************************************************
  reg         mod_r;        // Setups modified flag survives internal reset
  reg  [23:0] keyen_r;
  reg  [4:0]  lim_sel_r;
  reg  [3:0]  inner_lim_r [0:23];
  reg  [3:0]  outer_lim_r [0:23];
  reg  [23:0] calbusy_r;
  reg  [23:0] calerr_r;
  reg  [23:0] sterr_r;
  reg  [23:0] lowsig_r;
  reg  [7:0]  last_cmd_r;
  reg  [7:0]  cmd_prev_r;
  reg         init_done_r;
  reg         cal_done_r;
  wire        wb_hit = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire        wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];
  wire        any_err = |{calerr_r, sterr_r, lowsig_r};
  integer     i;

  always @(posedge mclk)
  begin
    if (srst)
      mod_r <= 1'b0;
    else if (wb_wr && wb_adr_i == `TKC_ADR_CTRL)
      mod_r <= wb_dat_i[`TKC_CTRL_MOD];
  end

  always @(posedge mclk)
  begin
    if (irst)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      keyen_r    <= `TKC_KEYEN_RST;
      lim_sel_r  <= 5'h00;
      cmd_rst_r  <= 1'b0;
      last_cmd_r <= 8'h00;
      cmd_prev_r <= 8'h00;
      for (i = 0; i < `TKC_NKEYS; i = i + 1)
      begin
        inner_lim_r[i] <= 4'h1;
        outer_lim_r[i] <= 4'h1;
      end
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (wb_wr)
      begin
        case (wb_adr_i)
          `TKC_ADR_KEYEN:
            keyen_r <= wb_dat_i[23:0];
          `TKC_ADR_LIMSEL:
            lim_sel_r <= wb_dat_i[4:0];
          `TKC_ADR_LIMDAT:
            if (lim_sel_r < `TKC_NKEYS)
            begin
              inner_lim_r[lim_sel_r] <= wb_dat_i[3:0];
              outer_lim_r[lim_sel_r] <= wb_dat_i[7:4];
            end
          `TKC_ADR_CMD:
          begin
            // Return-last-command answers the previous code inverted
            if (wb_dat_i[7:0] == `TKC_CMD_LASTCMD)
              last_cmd_r <= ~cmd_prev_r;
            else
              last_cmd_r <= wb_dat_i[7:0];
            cmd_prev_r <= wb_dat_i[7:0];
            if (wb_dat_i[7:0] == `TKC_CMD_FRESET)
              cmd_rst_r <= 1'b1;
          end
          default:
            last_cmd_r <= last_cmd_r;
        endcase
      end
      wb_dat_o <= 32'h00000000;
      if (wb_hit && !wb_we_i)
      begin
        case (wb_adr_i)
          `TKC_ADR_CTRL:    wb_dat_o <= {31'h0, mod_r};
          `TKC_ADR_STATUS:  wb_dat_o <= {26'h0, chirp_r, |calbusy_r,
                                         any_err, |active_r,
                                         ready_r, init_done_r};
          `TKC_ADR_KEYEN:   wb_dat_o <= {8'h00, keyen_r};
          `TKC_ADR_ACTIVE:  wb_dat_o <= {8'h00, active_r};
          `TKC_ADR_CALBUSY: wb_dat_o <= {8'h00, calbusy_r};
          `TKC_ADR_CALERR:  wb_dat_o <= {8'h00, calerr_r};
          `TKC_ADR_STERR:   wb_dat_o <= {8'h00, sterr_r};
          `TKC_ADR_LIMSEL:  wb_dat_o <= {27'h0, lim_sel_r};
          `TKC_ADR_LIMDAT:  wb_dat_o <= (lim_sel_r < `TKC_NKEYS) ?
                              {24'h0, outer_lim_r[lim_sel_r],
                               inner_lim_r[lim_sel_r]} : 32'h0;
          `TKC_ADR_CMD:     wb_dat_o <= {24'h0, last_cmd_r};
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ************************************************************
  // Init timer
  // ************************************************************
  reg [31:0] init_cnt_r;
  wire [31:0] init_end = mod_r ? INITMOD_CYC : INIT_CYC;
  always @(posedge mclk)
  begin
    if (irst)
    begin
      init_cnt_r  <= 32'h00000000;
      init_done_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      init_cnt_r <= init_cnt_r + 32'h00000001;
      if (init_cnt_r >= init_end - 32'h00000001)
        init_done_r <= 1'b1;
    end
  end

  // ************************************************************
  // Scan sequencer
  // ************************************************************
  localparam S_IDLE  = 2'h0;
  localparam S_BURST = 2'h1;
  localparam S_TEST  = 2'h2;

  reg [1:0]  state_r;
  reg [3:0]  inner_cnt_r [0:23];
  reg [3:0]  outer_cnt_r [0:23];
  reg [23:0] stepped_r;
  reg [2:0]  tries_r [0:23];
  reg [31:0] st_cnt_r;
  wire [3:0] ic = inner_cnt_r[key_sel_r] + 4'h1;
  integer    n;

  // Lowest enabled key at or above k, or 31 when none remain
  function [4:0] next_key;
    input [23:0] en;
    input [5:0]  k;
    integer j;
    begin
      next_key = 5'h1f;
      for (j = `TKC_NKEYS - 1; j >= 0; j = j - 1)
        if (en[j] && j >= k)
          next_key = j[4:0];
    end
  endfunction

  wire [4:0] first_key = next_key(keyen_r, 6'h00);
  wire [4:0] nxt_key   = next_key(keyen_r, {1'b0, key_sel_r} + 6'h01);
  wire       cur_cross = cross_in[key_sel_r];

  always @(posedge mclk)
  begin
    if (irst)
    begin
      state_r      <= S_IDLE;
      key_sel_r    <= 5'h00;
      burst_r      <= 1'b0;
      chirp_r      <= 1'b1;
      stest_slot_r <= 1'b0;
      active_r     <= 24'h000000;
      calbusy_r    <= 24'h000000;
      calerr_r     <= 24'h000000;
      sterr_r      <= 24'h000000;
      lowsig_r     <= 24'h000000;
      stepped_r    <= 24'h000000;
      cal_done_r   <= 1'b0;
      ready_r      <= 1'b0;
      st_cnt_r     <= 32'h00000000;
      for (n = 0; n < `TKC_NKEYS; n = n + 1)
      begin
        inner_cnt_r[n] <= 4'h0;
        outer_cnt_r[n] <= 4'h0;
        tries_r[n]     <= 3'h0;
      end
    end
    else
    begin
      chirp_r <= 1'b1;
      ready_r <= init_done_r & cal_done_r;
      st_cnt_r <= st_cnt_r + 32'h00000001;
      calbusy_r <= calbusy_r & keyen_r;
      lowsig_r <= lowsig_r | (low_sig_in & keyen_r);
      case (state_r)
        S_IDLE:
          if (init_done_r && first_key != 5'h1f)
          begin
            if (!cal_done_r && calbusy_r == 24'h0 &&
                calerr_r == 24'h0)
              calbusy_r <= keyen_r;
            key_sel_r <= first_key;
            burst_r   <= 1'b1;
            stepped_r <= 24'h000000;
            state_r   <= S_BURST;
          end
        S_BURST:
          if (sample_vld)
          begin
            if (calbusy_r[key_sel_r])
            begin
              if (cal_ok)
                calbusy_r[key_sel_r] <= 1'b0;
              else if (tries_r[key_sel_r] == `TKC_CAL_TRIES - 3'h1)
              begin
                calbusy_r[key_sel_r] <= 1'b0;
                calerr_r[key_sel_r]  <= 1'b1;
              end
              else
                tries_r[key_sel_r] <= tries_r[key_sel_r] + 3'h1;
              key_sel_r <= nxt_key;
            end
            else if (!cur_cross)
            begin
              inner_cnt_r[key_sel_r] <= 4'h0;
              outer_cnt_r[key_sel_r] <= 4'h0;
              active_r[key_sel_r]    <= 1'b0;
              key_sel_r <= nxt_key;
            end
            else if (ic < inner_lim_r[key_sel_r])
              inner_cnt_r[key_sel_r] <= ic;
            else
            begin
              inner_cnt_r[key_sel_r] <= 4'h0;
              if (!stepped_r[key_sel_r])
              begin
                stepped_r[key_sel_r] <= 1'b1;
                if (outer_cnt_r[key_sel_r] + 4'h1 >=
                    outer_lim_r[key_sel_r])
                  active_r[key_sel_r] <= cal_done_r;
                else
                  outer_cnt_r[key_sel_r] <=
                    outer_cnt_r[key_sel_r] + 4'h1;
              end
              key_sel_r <= nxt_key;
            end
            if (nxt_key == 5'h1f &&
                (calbusy_r[key_sel_r] || !cur_cross ||
                 ic >= inner_lim_r[key_sel_r]))
            begin
              burst_r      <= 1'b0;
              stest_slot_r <= 1'b1;
              state_r      <= S_TEST;
            end
          end
        S_TEST:
        begin
          // Every scan runs the full set, far inside the 1 s bound
          if (|fault_in)
            sterr_r <= sterr_r | keyen_r;
          st_cnt_r     <= 32'h00000000;
          stest_slot_r <= 1'b0;
          if (calbusy_r == 24'h0)
            cal_done_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default:
          state_r <= S_IDLE;
      endcase
      // Forced test slot when scans stall, e.g. no key enabled
      if (st_cnt_r >= STEST_CYC - 1 && state_r != S_TEST)
      begin
        burst_r      <= 1'b0;
        stest_slot_r <= 1'b1;
        state_r      <= S_TEST;
      end
    end
  end

endmodule // tkc_core
`default_nettype wire

// >>> tb/tkc_front_model.sv
// Acquisition front-end model feeding burst samples to the core
`default_nettype none
module tkc_front_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        burst_r,
  input  wire logic [3:0]  gap,
  input  wire logic [23:0] touch,
  input  wire logic        cal_good,
  output logic             sample_vld,
  output logic [23:0]      cross_in,
  output logic             cal_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_r;
  always_ff @(posedge mclk)
  begin
    if (srst || !burst_r)
      cnt_r <= '0;
    else
      cnt_r <= (cnt_r >= gap) ? 4'h0 : cnt_r + 4'h1;
  end
  // Lines carry the inverse pattern between samples
  assign sample_vld = burst_r && (cnt_r == gap);
  assign cross_in   = sample_vld ? touch : ~touch;
  assign cal_ok     = sample_vld ? cal_good : ~cal_good;
endmodule // tkc_front_model
`default_nettype wire

// >>> tb/tkc_core_properties.sv
// Port timing checker of the touch-key core
`default_nettype none
`include "tkc_regs.vh"
module tkc_core_props #(
  parameter INIT_CYC  = 50,
  parameter STEST_CYC = 2000
) (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        rst_pin_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        ready_r,
  input wire logic        chirp_r,
  input wire logic        stest_slot_r,
  input wire logic        burst_r,
  input wire logic [4:0]  key_sel_r,
  input wire logic [23:0] active_r
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PIN_LIM = `TKC_RSTPIN_CYC + 10;
  logic [31:0] up_cnt_r, gap_cnt_r, pin_cnt_r;
  logic        frst;
  assign frst = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                (wb_adr_i == `TKC_ADR_CMD) &&
                (wb_dat_i[7:0] == `TKC_CMD_FRESET);
  always_ff @(posedge mclk)
  begin
    up_cnt_r  <= (srst || frst || pin_cnt_r >= PIN_LIM) ? '0 : up_cnt_r + 1;
    gap_cnt_r <= (srst || stest_slot_r || !ready_r) ? '0 : gap_cnt_r + 1;
    pin_cnt_r <= (srst || rst_pin_n) ? '0 : pin_cnt_r + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  ack_timing_a: assert property (req_s |=> ack_s)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chirp_on_a: assert property (chirp_r)
    else $error("chirp modulation off");
  slot_pulse_a: assert property (stest_slot_r |=> !stest_slot_r)
    else $error("test slot longer than one cycle");
  stest_rate_a: assert property (gap_cnt_r <= STEST_CYC)
    else $error("self-test interval too long");
  init_time_a: assert property (ready_r && rst_pin_n |-> up_cnt_r >= INIT_CYC)
    else $error("ready before init time");
  pin_reset_a: assert property (pin_cnt_r == PIN_LIM |-> !ready_r && !active_r)
    else $error("long reset pulse did not reset");
  force_rst_a: assert property (frst |-> ##[1:4] (!ready_r && !active_r))
    else $error("force reset command ignored");
  act_ready_a: assert property (active_r != '0 |-> ready_r)
    else $error("key active before ready");
  key_range_a: assert property (burst_r |-> key_sel_r < 5'h18)
    else $error("burst on a key outside the matrix");
  slot_idle_a: assert property (stest_slot_r |-> !burst_r)
    else $error("test slot during a burst");
endmodule // tkc_core_props
bind tkc_core tkc_core_props #(.INIT_CYC(INIT_CYC), .STEST_CYC(STEST_CYC))
  u_props (.mclk, .srst, .rst_pin_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .ready_r, .chirp_r, .stest_slot_r,
  .burst_r, .key_sel_r, .active_r);
`default_nettype wire

// >>> tb/tkc_core_tb_top.sv
// Register-level testbench of the touch-key core
`default_nettype none
`include "tkc_regs.vh"
module tkc_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 0, srst = 1, rst_pin_n = 1, link_clk = 0, cal_good = 1;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, rdat;
  logic [23:0] low_sig_in = '0, touch = '0;
  logic [8:0]  fault_in = '0;
  logic [3:0]  gap = 4'h2;
  wire logic [31:0] wb_dat_o;
  wire logic [23:0] cross_in, active_r;
  wire logic [4:0]  key_sel_r;
  wire logic wb_ack_o, ready_r, burst_r, chirp_r, stest_slot_r;
  wire logic sample_vld, cal_ok;
  int n_fail = 0, cmp_count = 0;
  always #5 mclk = ~mclk;
  always #62.5 link_clk = ~link_clk;
  tkc_core #(.INIT_CYC(50), .INITMOD_CYC(100), .STEST_CYC(2000)) dut (
    .mclk, .srst, .rst_pin_n, .link_clk, .cross_in, .low_sig_in, .fault_in,
    .sample_vld, .cal_ok, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ready_r, .burst_r,
    .chirp_r, .key_sel_r, .stest_slot_r, .active_r);
  tkc_front_model u_front (.mclk, .srst, .burst_r, .gap, .touch, .cal_good,
    .sample_vld, .cross_in, .cal_ok);
  task automatic final_report;
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Wait for ack; only the watchdog ends a hung transfer
    @(posedge mclk);
    while (wb_ack_o !== 1'b1)
      @(posedge mclk);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(rdat & m, e);
  endtask
  // Bounded waits on ready and on test-slot pulses
  task automatic wait_ready;
    int n;
    for (n = 0; n < 20000 && ready_r !== 1'b1; n++)
      @(posedge mclk);
    if (n >= 20000)
      n_fail++;
  endtask
  task automatic wait_scans(input int k);
    int n;
    repeat (k)
    begin
      @(posedge mclk);
      for (n = 0; n < 2500 && stest_slot_r !== 1'b1; n++)
        @(posedge mclk);
      if (n >= 2500)
        n_fail++;
    end
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    final_report;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(`TKC_ADR_STATUS, 32'h2, 32'h0);
    rd_chk(`TKC_ADR_CTRL, '1, 32'h0);
    rd_chk(`TKC_ADR_KEYEN, '1, 32'h00ffffff);
    rd_chk(8'h3c, '1, 32'h0);
    wait_ready;
    rd_chk(`TKC_ADR_STATUS, 32'h30, 32'h20);
    rd_chk(`TKC_ADR_CALBUSY, '1, 32'h0);
    touch <= 24'h4;
    wait_scans(3);
    rd_chk(`TKC_ADR_ACTIVE, 32'h4, 32'h4);
    rd_chk(`TKC_ADR_STATUS, 32'h4, 32'h4);
    touch <= 24'h0;
    gap <= 4'h7;
    wb(1'b1, `TKC_ADR_LIMSEL, 32'h5);
    wb(1'b1, `TKC_ADR_LIMDAT, 32'h32);
    rd_chk(`TKC_ADR_LIMDAT, 32'hff, 32'h32);
    touch <= 24'h20;
    wait_scans(2);
    rd_chk(`TKC_ADR_ACTIVE, 32'h20, 32'h0);
    wait_scans(3);
    rd_chk(`TKC_ADR_ACTIVE, 32'h20, 32'h20);
    gap <= 4'h1;
    wb(1'b1, `TKC_ADR_KEYEN, 32'h00fffffe);
    touch <= 24'h1;
    wait_scans(4);
    rd_chk(`TKC_ADR_ACTIVE, 32'h1, 32'h0);
    fault_in <= 9'h004;
    wait_scans(2);
    rd_chk(`TKC_ADR_STATUS, 32'h8, 32'h8);
    rd_chk(`TKC_ADR_STERR, '1, 32'h00fffffe);
    fault_in <= 9'h000;
    touch <= 24'h0;
    wait_scans(1);
    rd_chk(`TKC_ADR_STATUS, 32'h8, 32'h8);
    wb(1'b1, `TKC_ADR_CMD, 32'h4);
    rd_chk(`TKC_ADR_STATUS, 32'ha, 32'h0);
    rd_chk(`TKC_ADR_STERR, '1, 32'h0);
    wait_ready;
    low_sig_in <= 24'h2;
    wait_scans(1);
    rd_chk(`TKC_ADR_STATUS, 32'h8, 32'h8);
    low_sig_in <= 24'h0;
    wb(1'b1, `TKC_ADR_CMD, 32'hf);
    wb(1'b1, `TKC_ADR_CMD, 32'hf);
    rd_chk(`TKC_ADR_CMD, 32'hff, 32'hf0);
    wb(1'b1, `TKC_ADR_CTRL, 32'h1);
    wb(1'b1, `TKC_ADR_CMD, 32'h4);
    rd_chk(`TKC_ADR_CTRL, 32'h1, 32'h1);
    wait_ready;
    rst_pin_n <= 1'b0;
    repeat (1010) @(posedge mclk);
    rst_pin_n <= 1'b1;
    chk(ready_r, 1'b0);
    wait_ready;
    cal_good <= 1'b0;
    gap <= 4'h7;
    wb(1'b1, `TKC_ADR_CMD, 32'h4);
    rd_chk(`TKC_ADR_CALERR, '1, 32'h0);
    wait_scans(4);
    rd_chk(`TKC_ADR_CALBUSY, '1, 32'h00ffffff);
    rd_chk(`TKC_ADR_CALERR, '1, 32'h0);
    wait_scans(1);
    rd_chk(`TKC_ADR_CALERR, '1, 32'h00ffffff);
    rd_chk(`TKC_ADR_CALBUSY, '1, 32'h0);
    final_report;
  end
endmodule // tkc_core_tb_top
`default_nettype wire
